/* logic/vtm_pkg.sv */
// Constants, types and state records for the voltage and temperature
// monitor. Assumes one 100 MHz core clock and a converter on its own clock.

package vtm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 100000;
  localparam int CLK_NS = 10;
  localparam int SCAN_MS = 200;
  localparam int SCAN_MAX_MS = 300;
  localparam int CHANNELS = 5;
  localparam int SLOT_CYC_DEF = SCAN_MS * CLK_KHZ / CHANNELS;
  localparam int GLITCH_NS = 50;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Widths, channel codes and status bits
  // ----------------------------------------------------------------
  localparam int TEMP_W = 11;
  localparam int VOLT_W = 8;
  localparam int NVOLT = 4;
  localparam int ST_W = 5;
  localparam logic [2:0] CH_TEMP = 3'h0;
  localparam logic [2:0] CH_LAST = 3'h4;
  localparam int ST_TEMP = 0;
  localparam logic [ST_W-1:0] STATUS_RST = 5'h00;

  // ----------------------------------------------------------------
  // Two-wire addresses and pin defaults
  // ----------------------------------------------------------------
  // Arbitrary upper address bits
  localparam logic [4:0] SLAVE_BASE = 5'h0a;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_ADD = 2;
  localparam logic [2:0] PIN_IDLE = 3'h3;

  typedef enum logic [1:0] {
    TM_DEFAULT = 2'b00,
    TM_ONESHOT = 2'b01,
    TM_COMPARE = 2'b10
  } temp_mode_t;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_AACK = 3'b010,
    I_RX = 3'b011,
    I_DACK = 3'b100,
    I_TX = 3'b101,
    I_MACK = 3'b110
  } i2c_state_t;

  typedef struct packed {
    logic [TEMP_W-1:0] temp_high;
    logic [NVOLT-1:0][VOLT_W-1:0] volt_low;
    logic [NVOLT-1:0][VOLT_W-1:0] volt_high;
  } limits_t;

  typedef struct packed {
    logic [TEMP_W-1:0] temp;
    logic [NVOLT-1:0][VOLT_W-1:0] volt;
  } results_t;

  typedef struct packed {
    logic [2:0][2:0] psync;
    logic [2:0] plvl;
    logic [2:0] filt;
    logic [2:0][2:0] fcnt;
    i2c_state_t ist;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rd_mode;
    logic ara_mode;
    logic add_idle;
    logic add_start;
    logic [1:0] addr_lo;
    logic sda_oe;
    logic [2:0] ch;
    logic [31:0] slot_cnt;
    logic busy;
    logic req_tgl;
    logic [2:0] ack_sync;
    logic ack_lvl;
    logic armed;
    logic pass_done;
    logic [ST_W-1:0] status;
    results_t res;
  } core_state_t;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [2:0] req_sync;
    logic req_lvl;
    logic seen;
    logic start;
    logic [2:0] chan;
    logic [TEMP_W-1:0] data;
    logic ack_tgl;
  } link_state_t;

endpackage

/* logic/vtm_monitor.sv */
// Sequencer, limit checks, alert latch and two-wire slave of the monitor.
// Assumes a converter front end clocked by adc_clk and an external bus
// buffer that resolves the open-drain pins from the enables.
`timescale 1ns/100ps

module vtm_monitor
  import vtm_pkg::*;
#(
  parameter int SLOT_CYCLES = SLOT_CYC_DEF
) (
  // Core clock and reset
  input wire logic clock,
  input wire logic srst,
  // Converter link
  input wire logic adc_clk,
  output logic adc_start,
  output logic [2:0] adc_chan,
  input wire logic adc_done,
  input wire logic [TEMP_W-1:0] adc_data,
  // Configuration
  input wire limits_t limits,
  input wire temp_mode_t temp_mode,
  input wire logic [ST_W-1:0] int_mask,
  input wire logic int_enable,
  // Two-wire pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic add_in,
  // Alert pin
  output logic alert_out,
  output logic alert_oe,
  // Results and status
  output results_t results,
  output logic [ST_W-1:0] int_status,
  output logic pass_done
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Level counts once second and third stages agree
  function automatic logic agree(input logic [2:0] s, input logic lvl);
    agree = (s[1] == s[2]) ? s[2] : lvl;
  endfunction

  // Voltage outside its window
  function automatic logic out_of_window(input logic [VOLT_W-1:0] v,
                                         input logic [VOLT_W-1:0] lo,
                                         input logic [VOLT_W-1:0] hi);
    out_of_window = (v < lo) || (v > hi);
  endfunction

  core_state_t r;
  core_state_t n;
  link_state_t lr;
  link_state_t ln;

  // ----------------------------------------------------------------
  // Core state update
  // ----------------------------------------------------------------
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic alert_c;
    logic acked;
    logic [ST_W-1:0] clr;
    logic [ST_W-1:0] set;
    logic [7:0] txb;
    logic over;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    acked = 1'b0;
    clr = '0;
    set = '0;
    txb = '0;
    over = 1'b0;
    n = r;
    n.pass_done = 1'b0;
    n.psync[PIN_SCL] = {r.psync[PIN_SCL][1:0], scl_in};
    n.psync[PIN_SDA] = {r.psync[PIN_SDA][1:0], sda_in};
    n.psync[PIN_ADD] = {r.psync[PIN_ADD][1:0], add_in};
    for (int i = 0; i < 3; i++) begin
      n.plvl[i] = agree(r.psync[i], r.plvl[i]);
      if (r.plvl[i] == r.filt[i]) begin
        n.fcnt[i] = '0;
      end else if (r.fcnt[i] == 3'(GLITCH_CYC - 1)) begin
        n.filt[i] = r.plvl[i];
        n.fcnt[i] = '0;
      end else begin
        n.fcnt[i] = r.fcnt[i] + 3'h1;
      end
    end
    scl_rise = n.filt[PIN_SCL] & ~r.filt[PIN_SCL];
    scl_fall = ~n.filt[PIN_SCL] & r.filt[PIN_SCL];
    start_c = r.filt[PIN_SCL] & n.filt[PIN_SCL] & r.filt[PIN_SDA]
              & ~n.filt[PIN_SDA];
    stop_c = r.filt[PIN_SCL] & n.filt[PIN_SCL] & ~r.filt[PIN_SDA]
             & n.filt[PIN_SDA];
    alert_c = int_enable && |(r.status & ~int_mask);

    // Two-wire slave
    if (r.ist == I_IDLE && r.filt[PIN_SCL] && r.filt[PIN_SDA]) begin
      n.add_idle = r.filt[PIN_ADD];
    end
    if (start_c) begin
      n.add_start = n.filt[PIN_ADD]; // Same filter lag as SDA
      n.ist = I_ADDR;
      n.bitcnt = '0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.ist = I_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      unique case (r.ist)
        I_IDLE: begin
        end
        I_ADDR: begin
          if (scl_rise) begin
            n.shreg = {r.shreg[6:0], r.filt[PIN_SDA]};
            n.bitcnt = r.bitcnt + 4'h1;
          end
          if (scl_fall && r.bitcnt == 4'h0) begin
            if (!r.add_idle) n.addr_lo = 2'b00;
            else if (!r.add_start) n.addr_lo = 2'b01;
            else if (!n.filt[PIN_ADD]) n.addr_lo = 2'b10;
            else n.addr_lo = 2'b11;
          end
          if (scl_fall && r.bitcnt == 4'h8) begin
            n.rd_mode = r.shreg[0];
            n.ara_mode = 1'b0;
            if (r.shreg[7:1] == {SLAVE_BASE, r.addr_lo}) begin
              acked = 1'b1;
            end else if (r.shreg[7:1] == ALERT_RESP_ADDR && r.shreg[0]
                         && alert_c) begin
              acked = 1'b1;
              n.ara_mode = 1'b1;
            end
            n.sda_oe = acked;
            n.ist = acked ? I_AACK : I_IDLE;
          end
        end
        I_AACK: begin
          if (scl_fall) begin
            n.bitcnt = '0;
            if (r.rd_mode) begin
              if (r.ara_mode) begin
                txb = {SLAVE_BASE, r.addr_lo, 1'b0};
              end else begin
                txb = {3'h0, r.status};
                clr = r.status;
                if (temp_mode == TM_COMPARE) clr[ST_TEMP] = 1'b0;
              end
              n.shreg = txb;
              n.sda_oe = ~txb[7];
              n.ist = I_TX;
            end else begin
              n.sda_oe = 1'b0;
              n.ist = I_RX;
            end
          end
        end
        I_RX: begin
          if (scl_rise) begin
            n.shreg = {r.shreg[6:0], r.filt[PIN_SDA]};
            n.bitcnt = r.bitcnt + 4'h1;
          end
          if (scl_fall && r.bitcnt == 4'h8) begin
            n.sda_oe = 1'b1;
            n.ist = I_DACK;
          end
        end
        I_DACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.bitcnt = '0;
            n.ist = I_RX;
          end
        end
        I_TX: begin
          if (scl_fall) begin
            n.shreg = {r.shreg[6:0], 1'b0};
            n.bitcnt = r.bitcnt + 4'h1;
            if (r.bitcnt == 4'h7) begin
              n.sda_oe = 1'b0;
              n.ist = I_MACK;
            end else begin
              n.sda_oe = ~r.shreg[6];
            end
          end
        end
        I_MACK: begin
          if (scl_rise) begin
            n.ist = r.filt[PIN_SDA] ? I_IDLE : I_AACK;
          end
        end
        default: begin
          n.ist = I_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end

    if (r.slot_cnt == 32'(SLOT_CYCLES - 1)) begin
      if (!r.busy) begin
        n.slot_cnt = '0;
        n.ch = (r.ch == CH_LAST) ? CH_TEMP : r.ch + 3'h1;
        n.pass_done = (r.ch == CH_LAST);
      end
    end else begin
      n.slot_cnt = r.slot_cnt + 32'h1;
    end
    if (r.slot_cnt == 32'h0 && !r.busy) begin
      n.busy = 1'b1;
      n.req_tgl = ~r.req_tgl;
    end

    // Conversion done from the link domain
    n.ack_sync = {r.ack_sync[1:0], lr.ack_tgl};
    n.ack_lvl = agree(r.ack_sync, r.ack_lvl);
    if (r.busy && n.ack_lvl != r.ack_lvl) begin
      n.busy = 1'b0;
      if (r.ch == CH_TEMP) begin
        n.res.temp = lr.data;
        over = $signed(lr.data) > $signed(limits.temp_high);
        unique case (temp_mode)
          TM_ONESHOT: begin
            set[ST_TEMP] = over && r.armed;
            n.armed = !over;
          end
          TM_COMPARE: begin
            n.armed = 1'b1;
          end
          default: begin
            set[ST_TEMP] = over;
            n.armed = 1'b1;
          end
        endcase
      end else begin
        n.res.volt[r.ch - 3'h1] = lr.data[VOLT_W-1:0];
        set[r.ch] = out_of_window(lr.data[VOLT_W-1:0],
                                  limits.volt_low[r.ch - 3'h1],
                                  limits.volt_high[r.ch - 3'h1]);
      end
    end

    n.status = (r.status & ~clr) | set;
    if (temp_mode == TM_COMPARE && r.busy && r.ch == CH_TEMP
        && n.ack_lvl != r.ack_lvl) begin
      n.status[ST_TEMP] = over;
    end

    if (srst) begin
      n = '0;
      n.psync = {3{PIN_IDLE}};
      n.plvl = PIN_IDLE;
      n.filt = PIN_IDLE;
      n.ist = I_IDLE;
      n.ch = CH_TEMP;
      n.armed = 1'b1;
      n.status = STATUS_RST;
    end
  end

  always_ff @(posedge clock) begin
    r <= n;
  end

  // ----------------------------------------------------------------
  // Converter link domain
  // ----------------------------------------------------------------
  always_comb begin
    ln = lr;
    ln.rst_sync = {lr.rst_sync[0], srst};
    ln.req_sync = {lr.req_sync[1:0], r.req_tgl};
    ln.req_lvl = agree(lr.req_sync, lr.req_lvl);
    // Channel is stable while a request is pending
    if (lr.req_lvl != lr.seen && !lr.start) begin
      ln.seen = lr.req_lvl;
      ln.start = 1'b1;
      ln.chan = r.ch;
    end
    if (lr.start && adc_done) begin
      ln.start = 1'b0;
      ln.data = adc_data;
      ln.ack_tgl = ~lr.ack_tgl;
    end
    if (lr.rst_sync[1]) begin
      ln = '0;
      ln.rst_sync = {lr.rst_sync[0], srst};
    end
  end

  always_ff @(posedge adc_clk) begin
    lr <= ln;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign adc_start = lr.start;
  assign adc_chan = lr.chan;
  assign sda_out = 1'b0;
  assign sda_oe = r.sda_oe;
  assign alert_out = 1'b0;
  assign alert_oe = int_enable && |(r.status & ~int_mask);
  assign results = r.res;
  assign int_status = r.status;
  assign pass_done = r.pass_done;

endmodule

/* verification/vtm_monitor_props.sv */
// Checker for the monitor: link order, alert cause, pass timing.
// Assumes it is bound to vtm_monitor and shares its slot length.
`timescale 1ns/100ps

module vtm_monitor_props
  import vtm_pkg::*;
#(
  parameter int SLOT_CYCLES = SLOT_CYC_DEF
) (
  // Clocks and reset
  input wire logic clock,
  input wire logic srst,
  input wire logic adc_clk,
  // Converter link
  input wire logic adc_start,
  input wire logic [2:0] adc_chan,
  input wire logic adc_done,
  // Configuration
  input wire limits_t limits,
  input wire temp_mode_t temp_mode,
  input wire logic [ST_W-1:0] int_mask,
  input wire logic int_enable,
  // Outputs
  input wire logic sda_oe,
  input wire logic alert_oe,
  input wire results_t results,
  input wire logic [ST_W-1:0] int_status,
  input wire logic pass_done
);
  logic [2:0] last_r;
  logic seen_r;
  logic armed_r;
  logic [31:0] gap_r;

  // Last channel asked for on the link
  always_ff @(posedge adc_clk) begin
    if (srst) begin
      seen_r <= 1'b0;
      last_r <= 3'h0;
    end else if (adc_start) begin
      seen_r <= 1'b1;
      last_r <= adc_chan;
    end
  end

  // Cycles between pass pulses
  always_ff @(posedge clock) begin
    if (srst) begin
      armed_r <= 1'b0;
      gap_r <= 32'h0;
    end else begin
      armed_r <= armed_r | pass_done;
      gap_r <= pass_done ? 32'h1 : gap_r + 32'h1;
    end
  end

  chk_reset_quiet: assert property (@(posedge clock)
    srst |=> int_status == STATUS_RST && !alert_oe && !sda_oe)
    else $error("state not clear after reset");
  chk_alert_cause: assert property (@(posedge clock) disable iff (srst)
    alert_oe == (int_enable && (int_status & ~int_mask) != 5'h00))
    else $error("alert does not follow unmasked status");
  chk_alert_enable: assert property (@(posedge clock) disable iff (srst)
    !int_enable |-> !alert_oe)
    else $error("alert while disabled");
  chk_temp_over: assert property (@(posedge clock) disable iff (srst)
    $rose(int_status[ST_TEMP]) |->
      $signed(results.temp) > $signed(limits.temp_high))
    else $error("temperature flag without excursion");
  for (genvar k = 0; k < NVOLT; k++) begin : g_volt
    chk_volt_window: assert property (@(posedge clock) disable iff (srst)
      $rose(int_status[k+1]) |-> results.volt[k] < limits.volt_low[k] ||
        results.volt[k] > limits.volt_high[k])
      else $error("voltage flag inside window");
  end
  chk_chan_next: assert property (@(posedge adc_clk) disable iff (srst)
    $rose(adc_start) && seen_r |->
      adc_chan == ((last_r == CH_LAST) ? CH_TEMP : last_r + 3'h1))
    else $error("channel out of order");
  chk_first_chan: assert property (@(posedge adc_clk) disable iff (srst)
    $rose(adc_start) && !seen_r |-> adc_chan == CH_TEMP)
    else $error("first channel not temperature");
  chk_chan_range: assert property (@(posedge adc_clk) disable iff (srst)
    adc_start |-> adc_chan <= CH_LAST)
    else $error("channel beyond own supply");
  chk_link_hold: assert property (@(posedge adc_clk) disable iff (srst)
    adc_start && !adc_done |=> adc_start && $stable(adc_chan))
    else $error("request dropped early");
  chk_link_drop: assert property (@(posedge adc_clk) disable iff (srst)
    adc_start && adc_done |=> !adc_start)
    else $error("request held after answer");
  chk_pass_gap: assert property (@(posedge clock) disable iff (srst)
    pass_done && armed_r |->
      gap_r >= 5 * SLOT_CYCLES && gap_r <= 6 * SLOT_CYCLES)
    else $error("pass length out of range");

  cov_pass: cover property (@(posedge clock) pass_done);
  cov_alert: cover property (@(posedge clock) $rose(alert_oe));
  cov_cmp: cover property (@(posedge clock)
    temp_mode == TM_COMPARE && int_status[ST_TEMP] && sda_oe);
endmodule

bind vtm_monitor vtm_monitor_props #(.SLOT_CYCLES(SLOT_CYCLES)) u_props (
  .clock, .srst, .adc_clk, .adc_start, .adc_chan, .adc_done, .limits,
  .temp_mode, .int_mask, .int_enable, .sda_oe, .alert_oe, .results,
  .int_status, .pass_done);

/* verification/adc_model.sv */
// Converter stand-in on the link clock: answers each request with a
// per-channel code after a set number of link cycles.
`timescale 1ns/100ps

module adc_model
  import vtm_pkg::*;
(
  // Link clock
  input wire logic adc_clk,
  // Request and answer
  input wire logic adc_start,
  input wire logic [2:0] adc_chan,
  output logic adc_done,
  output logic [TEMP_W-1:0] adc_data,
  // Codes per channel and answer delay
  input wire logic [4:0][TEMP_W-1:0] codes,
  input wire logic [3:0] lat
);
  logic [3:0] wait_r;

  initial begin
    adc_done = 1'b0;
    adc_data = '0;
    wait_r = 4'h0;
  end

  // Delay, then hold the word until the request drops
  always @(posedge adc_clk) begin
    if (!adc_start) begin
      wait_r <= 4'h0;
      adc_done <= 1'b0;
      adc_data <= ~adc_data; // Idle word flips, no stale code
    end else if (wait_r < lat) begin
      wait_r <= wait_r + 4'h1;
    end else begin
      adc_done <= 1'b1;
      adc_data <= codes[adc_chan];
    end
  end
endmodule

/* verification/voltage_temp_monitor_alert_tb.sv */
// Bench for the monitor: two-wire status reads, limits and modes.
// Assumes the converter model and a 1000-cycle slot.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  n_fail++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module voltage_temp_monitor_alert_tb
  import vtm_pkg::*;
;
  logic clock, adc_clk, srst, scl, sda_m, add_r, int_enable;
  logic adc_start, adc_done, sda_oe, alert_oe, pass_done, ack;
  logic sda_out, alert_out, add_sda;
  logic [2:0] adc_chan;
  logic [TEMP_W-1:0] adc_data;
  logic [ST_W-1:0] int_mask, int_status;
  logic [7:0] rd;
  logic [3:0] lat;
  logic [4:0][TEMP_W-1:0] codes;
  limits_t limits;
  temp_mode_t temp_mode;
  results_t results, exp_r;
  int checked, n_fail, cyc;
  // Open-drain pins: a low drive wins over the pull-up
  wire logic sda_w = sda_m & (~sda_oe | sda_out);
  wire logic alert_n = ~alert_oe | alert_out;
  // Address pin tied to ground or supply, or to the data line
  wire logic add_w = add_sda ? sda_w : add_r;

  vtm_monitor #(.SLOT_CYCLES(1000)) uut (
    .clock, .srst, .adc_clk, .adc_start, .adc_chan, .adc_done, .adc_data,
    .limits, .temp_mode, .int_mask, .int_enable, .scl_in(scl),
    .sda_in(sda_w), .sda_out, .sda_oe, .add_in(add_w), .alert_out,
    .alert_oe, .results, .int_status, .pass_done);
  adc_model u_adc (.adc_clk, .adc_start, .adc_chan, .adc_done, .adc_data,
    .codes, .lat);

  // Core and link clocks, unrelated phase
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    adc_clk = 1'b0;
    #3;
    forever #6 adc_clk = ~adc_clk;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 70000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic note(input string s);
    $display("test %s finished", s);
  endtask
  task automatic hp();
    repeat (20) @(negedge clock);
  endtask
  task automatic wait_pass();
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (pass_done !== 1'b1 && n < 20000);
    if (pass_done !== 1'b1) begin
      n_fail++;
      stop_test();
    end
  endtask
  // One bus bit, data set while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    hp();
    scl = 1'b1;
    hp();
    r = sda_w;
    hp();
    scl = 1'b0;
    hp();
  endtask
  // Addressed one-byte read ending in NACK and STOP
  task automatic i2c_rd(input logic [6:0] a, output logic k,
                        output logic [7:0] d);
    logic r;
    logic [7:0] b;
    b = {a, 1'b1};
    sda_m = 1'b0;
    hp();
    scl = 1'b0;
    hp();
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    k = ~r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
    sda_m = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_m = 1'b1;
    hp();
  endtask
  // Addressed one-byte write ending in STOP; k is both acks
  task automatic i2c_wr(input logic [6:0] a, input logic [7:0] v,
                        output logic k);
    logic r;
    logic [7:0] b;
    b = {a, 1'b0};
    sda_m = 1'b0;
    hp();
    scl = 1'b0;
    hp();
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    k = ~r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    k = k & ~r;
    sda_m = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_m = 1'b1;
    hp();
  endtask

  // Main sequence
  initial begin
    srst = 1'b1;
    scl = 1'b1;
    sda_m = 1'b1;
    add_r = 1'b1;
    add_sda = 1'b0;
    lat = 4'h1;
    int_enable = 1'b1;
    int_mask = 5'h00;
    temp_mode = TM_DEFAULT;
    codes = {11'h370, 11'h760, 11'h650, 11'h540, 11'h0a0};
    limits.temp_high = 11'h3ff;
    limits.volt_low = {4{8'h10}};
    limits.volt_high = {4{8'hf0}};
    exp_r.temp = 11'h0a0;
    exp_r.volt = {8'h70, 8'h60, 8'h50, 8'h40};
    repeat (5) @(negedge clock);
    srst = 1'b0;
    `CHK("status", 5'h00, int_status)
    `CHK("alert", 1'b0, alert_oe)
    wait_pass();
    `CHK("results", exp_r, results)
    `CHK("status", 5'h00, int_status)
    note("clean pass");
    limits.temp_high = 11'h7f0;
    limits.volt_high[3] = 8'h60;
    wait_pass();
    `CHK("status", 5'h11, int_status)
    `CHK("alert", 1'b1, alert_oe)
    `CHK("alert pin", 1'b0, alert_n)
    int_mask = 5'h11;
    @(negedge clock);
    `CHK("alert", 1'b0, alert_oe)
    int_mask = 5'h00;
    int_enable = 1'b0;
    @(negedge clock);
    `CHK("alert", 1'b0, alert_oe)
    int_enable = 1'b1;
    note("limits");
    temp_mode = TM_COMPARE;
    i2c_rd(7'h2b, ack, rd);
    limits.volt_high[3] = 8'hf0;
    `CHK("read", 9'h111, {ack, rd})
    `CHK("status", 5'h01, int_status)
    `CHK("alert", 1'b1, alert_oe)
    i2c_wr(7'h2b, 8'h5a, ack);
    `CHK("write ack", 1'b1, ack)
    `CHK("status", 5'h01, int_status)
    add_r = 1'b0;
    hp();
    i2c_rd(7'h0c, ack, rd);
    `CHK("ara", 9'h150, {ack, rd})
    i2c_rd(7'h2b, ack, rd);
    `CHK("ack", 1'b0, ack)
    add_sda = 1'b1;
    hp();
    i2c_rd(7'h29, ack, rd);
    `CHK("read", 9'h101, {ack, rd})
    add_sda = 1'b0;
    note("reads");
    codes[0] = 11'h7e0;
    lat = 4'hc;
    wait_pass();
    wait_pass();
    `CHK("temp", 11'h7e0, results.temp)
    `CHK("status", 5'h00, int_status)
    i2c_rd(7'h0c, ack, rd);
    `CHK("ara", 1'b0, ack)
    note("comparator");
    temp_mode = TM_ONESHOT;
    wait_pass();
    codes[0] = 11'h0a0;
    wait_pass();
    i2c_rd(7'h28, ack, rd);
    `CHK("read", 9'h101, {ack, rd})
    wait_pass();
    wait_pass();
    `CHK("status", 5'h00, int_status)
    note("one-time");
    stop_test();
  end
endmodule
